/* hw/sac_pkg.sv */
// Shared constants and types for the SAR converter control block.
// Assumes a 10 MHz system clock and an APB master with 32-bit data.
package sac_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_OPTION   = 8'h94;
  localparam logic [7:0]  IDX_FLAGS    = 8'h95;
  localparam logic [7:0]  IDX_RES_LOW  = 8'hAA;
  localparam logic [7:0]  IDX_RES_HIGH = 8'hAB;
  localparam logic [7:0]  IDX_CHREF    = 8'hAE;
  localparam logic [7:0]  IDX_AUX      = 8'hF8;
  localparam logic [11:0] ADDR_OPTION   = {2'b00, IDX_OPTION, 2'b00};
  localparam logic [11:0] ADDR_FLAGS    = {2'b00, IDX_FLAGS, 2'b00};
  localparam logic [11:0] ADDR_RES_LOW  = {2'b00, IDX_RES_LOW, 2'b00};
  localparam logic [11:0] ADDR_RES_HIGH = {2'b00, IDX_RES_HIGH, 2'b00};
  localparam logic [11:0] ADDR_CHREF    = {2'b00, IDX_CHREF, 2'b00};
  localparam logic [11:0] ADDR_AUX      = {2'b00, IDX_AUX, 2'b00};

  // Field positions
  localparam int OPT_RATE_LSB  = 2;
  localparam int FLG_DONE_BIT  = 4;
  localparam int AUX_START_BIT = 4;
  localparam int CH_CHAN_LSB   = 4;
  localparam int CH_REF_LSB    = 2;
  localparam int CH_FORCE_BIT  = 1;

  // Reset values and writable masks
  localparam logic [7:0] OPTION_RST  = 8'h00;
  localparam logic [7:0] OPTION_MASK = 8'hBF;
  localparam logic [7:0] CHREF_RST   = 8'hF0;
  localparam logic [7:0] CHREF_MASK  = 8'hFE;
  localparam logic [7:0] AUX_RST     = 8'h00;

  // Channel and reference codes
  localparam logic [3:0] CH_RESERVED  = 4'hA;
  localparam logic [3:0] CH_BANDGAP   = 4'hB;
  localparam logic [1:0] REF_SUPPLY   = 2'h0;
  localparam logic [1:0] REF_INTERNAL = 2'h1;

  // Clock divide ratios per rate code 00..11
  localparam logic [5:0] DIV_RATE0 = 6'h20;
  localparam logic [5:0] DIV_RATE1 = 6'h10;
  localparam logic [5:0] DIV_RATE2 = 6'h08;
  localparam logic [5:0] DIV_RATE3 = 6'h04;

  // Conversion timing in converter clocks
  localparam int RES_BITS      = 12;
  localparam int BIT_CYCLES    = 2;
  localparam int CONV_CYCLES   = 50;
  localparam int SAMPLE_CYCLES = CONV_CYCLES - RES_BITS * BIT_CYCLES;

  typedef enum logic [1:0] {PM_RUN, PM_IDLE, PM_HALT, PM_STOP} sac_pmode_e;
  typedef enum {ST_IDLE, ST_SAMPLE, ST_CONVERT} sac_state_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } sac_apb_req_s;

  typedef struct packed {
    logic [3:0]  muxChannel;
    logic        channelValid;
    logic        refInternal;
    logic        refValid;
    logic        bandgapEnable;
    logic        sampleEn;
    logic [11:0] trialCode;
  } sac_analog_s;

endpackage : sac_pkg

/* hw/sac_clk_div.sv */
// Divider that turns the system clock into a converter clock enable.
// Assumes restart is a same-clock pulse from the conversion control.
`timescale 1ns/1ps
module sac_clk_div
  import sac_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       restart,
  input  wire logic [1:0] rateSel,
  output logic            tick
);

  logic [5:0] divCnt_reg;
  logic [5:0] divLimit;

  always_comb begin
    unique case (rateSel)
      2'b00: divLimit = DIV_RATE0 - 6'h01;
      2'b01: divLimit = DIV_RATE1 - 6'h01;
      2'b10: divLimit = DIV_RATE2 - 6'h01;
      2'b11: divLimit = DIV_RATE3 - 6'h01;
    endcase
  end

  // Restart counts its own edge, so the registered tick lands on
  // whole periods after the start write
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      divCnt_reg <= 6'h00;
    end else if (restart) begin
      divCnt_reg <= 6'h01;
    end else if (divCnt_reg >= divLimit) begin
      divCnt_reg <= 6'h00;
    end else begin
      divCnt_reg <= divCnt_reg + 6'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n || restart) begin
      tick <= 1'b0;
    end else begin
      tick <= (divCnt_reg >= divLimit);
    end
  end

endmodule : sac_clk_div

/* hw/sac_adc_ctrl.sv */
// SAR converter control: APB registers, sequencing and result capture.
// Assumes the comparator output is asynchronous; power mode and
// interrupt enable come from logic on mclk.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
module sac_adc_ctrl
  import sac_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         reset_n,
  input  wire sac_apb_req_s apbReq,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  input  wire logic         compIn,
  input  wire sac_pmode_e   powerMode,
  input  wire logic         adcIntEn,
  output sac_analog_s       analogCtrl,
  output logic              adcIrq
);

  logic [7:0]  option_reg;
  logic [7:0]  chref_reg;
  logic [7:0]  aux_reg;
  logic        doneFlag_reg;
  logic [7:0]  resHigh_reg;
  logic [3:0]  resLow_reg;
  logic [11:0] approx_reg;
  logic [11:0] bitMask_reg;
  logic [5:0]  tickCnt_reg;
  sac_state_e  state_reg;
  logic [2:0]  compSync_reg;
  logic        compStable_reg;
  logic        tick;
  logic        setupPhase;
  logic        wrEn;
  logic        startWr;
  logic        stopWr;
  logic        doneEvt;
  logic        flagClr;
  logic        mapped;
  logic [7:0]  rdByte;
  logic [11:0] finalCode;

  assign setupPhase = apbReq.psel && !apbReq.penable;
  assign wrEn = apbReq.psel && apbReq.penable && pready && apbReq.pwrite;
  assign startWr = wrEn && apbReq.paddr == ADDR_AUX
                   && apbReq.pwdata[AUX_START_BIT];
  assign stopWr = wrEn && apbReq.paddr == ADDR_AUX
                  && !apbReq.pwdata[AUX_START_BIT];
  assign flagClr = startWr || wrEn && apbReq.paddr == ADDR_FLAGS
                   && !apbReq.pwdata[FLG_DONE_BIT];
  assign doneEvt = state_reg == ST_CONVERT && tick
                   && tickCnt_reg == 6'(CONV_CYCLES - 1);
  // Last bit resolved in the same edge as the capture
  assign finalCode = compStable_reg ? approx_reg
                                    : (approx_reg & ~bitMask_reg);

  sac_clk_div u_div (
    .mclk    (mclk),
    .reset_n (reset_n),
    .restart (startWr),
    .rateSel (option_reg[OPT_RATE_LSB +: 2]),
    .tick    (tick)
  );

  // Comparator crosses in from the analog side
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      compSync_reg <= 3'h0;
    end else begin
      compSync_reg <= {compSync_reg[1:0], compIn};
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      compStable_reg <= 1'b0;
    end else if (compSync_reg[1] == compSync_reg[2]) begin
      compStable_reg <= compSync_reg[2];
    end
  end

  always_comb begin
    mapped = 1'b1;
    rdByte = 8'h00;
    unique case (apbReq.paddr)
      ADDR_OPTION:   rdByte = option_reg;
      ADDR_FLAGS:    rdByte = 8'(doneFlag_reg) << FLG_DONE_BIT;
      ADDR_RES_LOW:  rdByte = {resLow_reg, 4'h0};
      ADDR_RES_HIGH: rdByte = resHigh_reg;
      ADDR_CHREF:    rdByte = chref_reg;
      ADDR_AUX:      rdByte = aux_reg;
      default:       mapped = 1'b0;
    endcase
  end

  // Answer is prepared in the setup cycle, so no wait states
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setupPhase;
      pslverr <= setupPhase && !mapped;
      if (setupPhase && !apbReq.pwrite) begin
        prdata <= {24'h00_0000, rdByte};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      option_reg <= OPTION_RST;
    end else if (wrEn && apbReq.paddr == ADDR_OPTION) begin
      option_reg <= apbReq.pwdata[7:0] & OPTION_MASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      chref_reg <= CHREF_RST;
    end else if (wrEn && apbReq.paddr == ADDR_CHREF) begin
      chref_reg <= apbReq.pwdata[7:0] & CHREF_MASK;
    end
  end

  // A new start write wins over the end of the running one
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      aux_reg <= AUX_RST;
    end else if (wrEn && apbReq.paddr == ADDR_AUX) begin
      aux_reg <= apbReq.pwdata[7:0];
    end else if (doneEvt) begin
      aux_reg[AUX_START_BIT] <= 1'b0;
    end
  end

  // Set wins over any clear in the same cycle
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      doneFlag_reg <= 1'b0;
    end else if (doneEvt) begin
      doneFlag_reg <= 1'b1;
    end else if (flagClr) begin
      doneFlag_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      adcIrq <= 1'b0;
    end else begin
      adcIrq <= (doneEvt || doneFlag_reg && !flagClr) && adcIntEn;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
    end else if (startWr) begin
      state_reg <= ST_SAMPLE;
    end else if (stopWr || doneEvt) begin
      state_reg <= ST_IDLE;
    end else if (state_reg == ST_SAMPLE && tick
                 && tickCnt_reg == 6'(SAMPLE_CYCLES - 1)) begin
      state_reg <= ST_CONVERT;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n || startWr) begin
      tickCnt_reg <= 6'h00;
    end else if (state_reg != ST_IDLE && tick) begin
      tickCnt_reg <= tickCnt_reg + 6'h01;
    end
  end

  // Each bit: trial on the first clock, decision on the second
  always_ff @(posedge mclk) begin
    if (!reset_n || startWr) begin
      approx_reg  <= 12'h000;
      bitMask_reg <= 12'h000;
    end else if (tick && state_reg == ST_SAMPLE
                 && tickCnt_reg == 6'(SAMPLE_CYCLES - 1)) begin
      approx_reg  <= 12'h800;
      bitMask_reg <= 12'h800;
    end else if (tick && state_reg == ST_CONVERT && tickCnt_reg[0]) begin
      approx_reg  <= finalCode | (bitMask_reg >> 1);
      bitMask_reg <= bitMask_reg >> 1;
    end
  end

  // Both bytes in the flag's edge; no torn result
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      resHigh_reg <= 8'h00;
      resLow_reg  <= 4'h0;
    end else if (doneEvt) begin
      resHigh_reg <= finalCode[11:4];
      resLow_reg  <= finalCode[3:0];
    end
  end

  // Reference choice left to software when bandgap is measured
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      analogCtrl <= '0;
    end else begin
      analogCtrl.muxChannel <= chref_reg[CH_CHAN_LSB +: 4];
      analogCtrl.channelValid <=
        chref_reg[CH_CHAN_LSB +: 4] != CH_RESERVED;
      analogCtrl.refInternal <=
        chref_reg[CH_REF_LSB +: 2] == REF_INTERNAL;
      analogCtrl.refValid <=
        chref_reg[CH_REF_LSB +: 2] <= REF_INTERNAL;
      analogCtrl.bandgapEnable <=
        !(powerMode == PM_HALT || powerMode == PM_STOP)
        && (chref_reg[CH_CHAN_LSB +: 4] == CH_BANDGAP
            || chref_reg[CH_FORCE_BIT]);
      analogCtrl.sampleEn <= state_reg == ST_SAMPLE;
      analogCtrl.trialCode <= approx_reg;
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  logic [11:0] convAge_reg;
  logic [5:0]  divNow;
  assign divNow = DIV_RATE0 >> option_reg[OPT_RATE_LSB +: 2];
  always_ff @(posedge mclk) begin
    if (!reset_n || startWr) begin
      convAge_reg <= 12'h000;
    end else if (state_reg != ST_IDLE) begin
      convAge_reg <= convAge_reg + 12'h001;
    end
  end
  property p_start_self_clear;
    doneEvt && !startWr |=> !aux_reg[AUX_START_BIT] && state_reg == ST_IDLE;
  endproperty
  a_start_self_clear: assert property (p_start_self_clear)
    else $error("start bit not cleared at end");

  property p_write_zero_stop;
    stopWr |=> !aux_reg[AUX_START_BIT] && state_reg == ST_IDLE;
  endproperty
  a_write_zero_stop: assert property (p_write_zero_stop)
    else $error("zero write did not stop");

  property p_flag_set;
    doneEvt |=> doneFlag_reg ##1 (doneFlag_reg || $past(wrEn));
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("done flag not set");

  property p_flag_clr_start;
    startWr && !doneEvt |=> !doneFlag_reg;
  endproperty
  a_flag_clr_start: assert property (p_flag_clr_start)
    else $error("start write did not clear flag");

  property p_flag_one_keeps;
    wrEn && apbReq.paddr == ADDR_FLAGS && apbReq.pwdata[FLG_DONE_BIT]
      && doneFlag_reg |=> doneFlag_reg;
  endproperty
  a_flag_one_keeps: assert property (p_flag_one_keeps)
    else $error("writing one cleared flag");

  property p_irq_enabled;
    $rose(adcIrq) |-> $past(adcIntEn) && $past(doneFlag_reg || doneEvt);
  endproperty
  a_irq_enabled: assert property (p_irq_enabled)
    else $error("interrupt without enable");

  property p_conv_length;
    doneEvt |-> convAge_reg + 12'h001 == 12'(CONV_CYCLES) * 12'(divNow);
  endproperty
  a_conv_length: assert property (p_conv_length)
    else $error("conversion length wrong");

  property p_sample_phase;
    $fell(analogCtrl.sampleEn) && state_reg == ST_CONVERT
      |-> tickCnt_reg == 6'(SAMPLE_CYCLES) && bitMask_reg == 12'h800;
  endproperty
  a_sample_phase: assert property (p_sample_phase)
    else $error("sample phase length wrong");

  property p_result_with_flag;
    $rose(doneFlag_reg) |-> {resHigh_reg, resLow_reg} == $past(finalCode);
  endproperty
  a_result_with_flag: assert property (p_result_with_flag)
    else $error("result not loaded with flag");

  property p_bandgap_halt;
    powerMode == PM_HALT || powerMode == PM_STOP |=> !analogCtrl.bandgapEnable;
  endproperty
  a_bandgap_halt: assert property (p_bandgap_halt)
    else $error("bandgap on in halt or stop");

  property p_bandgap_auto;
    chref_reg[7:4] == CH_BANDGAP && powerMode == PM_RUN
      |=> analogCtrl.bandgapEnable;
  endproperty
  a_bandgap_auto: assert property (p_bandgap_auto)
    else $error("bandgap not enabled for its channel");

  property p_reserved_chan;
    chref_reg[7:4] == CH_RESERVED |=> !analogCtrl.channelValid;
  endproperty
  a_reserved_chan: assert property (p_reserved_chan)
    else $error("reserved channel marked valid");

  c_done: cover property (doneEvt);
  c_abort: cover property (state_reg == ST_CONVERT && stopWr);
  c_restart: cover property (state_reg != ST_IDLE && startWr);
  c_clash: cover property (doneEvt && wrEn && apbReq.paddr == ADDR_FLAGS);

endmodule : sac_adc_ctrl

/* test/sac_conv_model.sv */
// Behavioural analog multiplexer, sample-and-hold and comparator.
// Assumes trialCode and sampleEn come straight from the control block.
`timescale 1ns/1ps
module sac_conv_model
  import sac_pkg::*;
(
  input  wire logic        mclk,
  input  wire sac_analog_s analogCtrl,
  output logic             compIn
);
  logic [11:0] heldLevel = 12'h000;
  logic [11:0] pinLevel;

  // Every channel shows its own level
  assign pinLevel = {analogCtrl.muxChannel, ~analogCtrl.muxChannel,
                     analogCtrl.muxChannel};

  always_ff @(posedge mclk) begin
    if (analogCtrl.sampleEn) begin
      // Wrong reference with bandgap ruins the sample
      if (analogCtrl.muxChannel == CH_BANDGAP &&
          analogCtrl.refInternal) begin
        heldLevel <= ~pinLevel;
      end else begin
        heldLevel <= pinLevel;
      end
    end
  end

  // Level sits half a step above its code, so no tie at the last bit
  assign compIn = {heldLevel, 1'b1} > {analogCtrl.trialCode, 1'b0};
endmodule : sac_conv_model

/* test/tb_top.sv */
// Self-checking bench: APB register tasks and conversion sequences.
// Assumes the converter model drives compIn from the analog outputs.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin \
  checked++; \
  if ((got) !== (exp)) begin \
    errors++; \
    $display("[ERR] %s exp %0h got %0h", nm, exp, got); \
  end \
end
module tb_top
  import sac_pkg::*;
;
  logic         mclk;
  logic         reset_n;
  sac_apb_req_s apbReq;
  logic         pready;
  logic [31:0]  prdata;
  logic         pslverr;
  logic         compIn;
  sac_pmode_e   powerMode;
  logic         adcIntEn;
  sac_analog_s  analogCtrl;
  logic         adcIrq;
  logic [31:0]  rd;
  logic         er;
  int           errors = 0;
  int           checked = 0;

  sac_adc_ctrl uut (.mclk(mclk), .reset_n(reset_n), .apbReq(apbReq),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .compIn(compIn),
    .powerMode(powerMode), .adcIntEn(adcIntEn), .analogCtrl(analogCtrl),
    .adcIrq(adcIrq));
  sac_conv_model partner (.mclk(mclk), .analogCtrl(analogCtrl),
    .compIn(compIn));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic close_out;
    if (errors == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  // Request held until pready is seen; data taken at that edge
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    apbReq <= '{1'b1, 1'b0, wr, a, {24'h0, d}};
    @(posedge mclk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) errors++;
    rd = prdata;
    er = pslverr;
    apbReq <= '0;
  endtask : xfer

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input string nm, input logic [11:0] a,
                       input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    `CHK(nm, {24'h0, e}, rd)
  endtask : rdchk

  // Analog outputs are registered behind the register write
  task automatic settle;
    repeat (2) @(negedge mclk);
  endtask : settle

  task automatic run_conv(input logic [1:0] rate, input logic [3:0] ch,
                          input logic en);
    int n;
    int s;
    int div;
    logic [11:0] v;
    n = 0;
    s = 0;
    div = 32 >> rate;
    v = {ch, ~ch, ch};
    adcIntEn <= en;
    wr(ADDR_OPTION, {4'h0, rate, 2'b00});
    wr(ADDR_CHREF, {ch, 4'h0});
    wr(ADDR_AUX, 8'h10);
    do begin
      @(negedge mclk);
      n++;
      if (analogCtrl.sampleEn === 1'b1) s++;
    end while ((adcIrq !== 1'b1 || !en) && n < 50 * div + 5);
    if (en) `CHK("cycles", 50 * div + 1, n)
    else `CHK("irq off", 1'b0, adcIrq)
    `CHK("sample", SAMPLE_CYCLES * div, s)
    rdchk("flag", ADDR_FLAGS, 8'h10);
    rdchk("start", ADDR_AUX, 8'h00);
    rdchk("high", ADDR_RES_HIGH, v[11:4]);
    rdchk("low", ADDR_RES_LOW, {v[3:0], 4'h0});
  endtask : run_conv

  initial begin
    repeat (40000) @(posedge mclk);
    errors++;
    close_out;
  end

  initial begin
    apbReq = '0;
    reset_n = 1'b0;
    adcIntEn = 1'b0;
    powerMode = PM_RUN;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    rdchk("option", ADDR_OPTION, OPTION_RST);
    rdchk("flags", ADDR_FLAGS, 8'h00);
    rdchk("chref", ADDR_CHREF, CHREF_RST);
    rdchk("aux", ADDR_AUX, AUX_RST);
    wr(ADDR_RES_HIGH, 8'hFF);
    rdchk("high ro", ADDR_RES_HIGH, 8'h00);
    xfer(1'b0, 12'h000, 8'h00);
    `CHK("unmapped", 1'b1, er)
    wr(ADDR_OPTION, 8'hFF);
    rdchk("opt mask", ADDR_OPTION, OPTION_MASK);
    for (int c = 0; c < 16; c++) begin
      wr(ADDR_CHREF, {c[3:0], c[1:0], 2'b00});
      settle;
      `CHK("mux", c[3:0], analogCtrl.muxChannel)
      `CHK("valid", (c != 10), analogCtrl.channelValid)
      `CHK("bandgap", (c == 11), analogCtrl.bandgapEnable)
      `CHK("ref int", (c[1:0] == 2'd1), analogCtrl.refInternal)
      `CHK("ref ok", !c[1], analogCtrl.refValid)
    end
    wr(ADDR_CHREF, 8'h32);
    for (int m = 0; m < 4; m++) begin
      powerMode <= sac_pmode_e'(m);
      settle;
      `CHK("force", (m < 2), analogCtrl.bandgapEnable)
    end
    wr(ADDR_CHREF, 8'hB0);
    settle;
    `CHK("stop bg", 1'b0, analogCtrl.bandgapEnable)
    powerMode <= PM_RUN;
    // Fast codes break the converter limit; timing and result are both judged
    for (int r = 0; r < 4; r++) begin
      run_conv(r[1:0], {r[1:0], 2'b01}, 1'b1);
    end
    wr(ADDR_FLAGS, 8'hFF);
    rdchk("flag keep", ADDR_FLAGS, 8'h10);
    wr(ADDR_FLAGS, 8'hEF);
    rdchk("flag clr", ADDR_FLAGS, 8'h00);
    @(negedge mclk);
    `CHK("irq clr", 1'b0, adcIrq)
    run_conv(2'd3, 4'h2, 1'b1);
    wr(ADDR_AUX, 8'h10);
    rdchk("flag start", ADDR_FLAGS, 8'h00);
    wr(ADDR_AUX, 8'h00);
    rdchk("start clr", ADDR_AUX, 8'h00);
    repeat (250) @(negedge mclk);
    rdchk("aborted", ADDR_FLAGS, 8'h00);
    run_conv(2'd1, 4'hE, 1'b0);
    close_out;
  end
endmodule : tb_top
